// >>> shared/bbc_params.svh
`ifndef BBC_PARAMS_SVH
`define BBC_PARAMS_SVH
// Register byte offsets
`define BBC_OFS_CH1_CFG   8'h00
`define BBC_OFS_CH2_CFG   8'h04
`define BBC_OFS_CH1_ADDR  8'h08
`define BBC_OFS_CH1_MASK  8'h0c
`define BBC_OFS_CH2_ADDR  8'h10
`define BBC_OFS_CH2_MASK  8'h14
`define BBC_OFS_CH1_COUNT 8'h18
`define BBC_OFS_CH3_CFG   8'h1c
`define BBC_OFS_STATUS    8'h20
`define BBC_OFS_IRQ_MASK  8'h24
`define BBC_OFS_CNT_NOW   8'h28
// Channel config field positions
`define BBC_CFG_ADDRESS_SPACE_ID_DC   0
`define BBC_CFG_ADDR_DC   1
`define BBC_CFG_BUS_LO    2
`define BBC_CFG_DIR_LO    4
`define BBC_CFG_COUNT_DC  6
`define BBC_CFG_ADDRESS_SPACE_ID_LO   8
// Channel 3 field positions
`define BBC_CH3_TLB_EN    0
`define BBC_CH3_IO_EN     1
`define BBC_CH3_IO_WR     2
// Reset values and maximum count
`define BBC_RST_CFG       32'h0000_0003
`define BBC_RST_COUNT     12'h001
`define BBC_RST_ADDRESS_SPACE_ID      8'h00
`define BBC_MAX_COUNT     12'hfff
`endif

// >>> shared/bbc_pkg.sv
package bbc_pkg;
    typedef enum logic [1:0] {BS_ALL, BS_DATA, BS_DMA, BS_RSV} bbc_bus_sel_t;
    typedef enum logic [1:0] {DIR_RW, DIR_READ, DIR_WRITE, DIR_RSV} bbc_dir_sel_t;

    typedef struct packed {
        logic         valid;
        logic [31:0]  addr;
        logic         write;
        logic         dma;
        logic [7:0]   address_space_id;
    } bbc_bus_cycle_t;

    typedef struct packed {
        logic [7:0]   address_space_id;
        logic         spare;
        logic         count_dc;
        bbc_dir_sel_t dir;
        bbc_bus_sel_t bus;
        logic         addr_dc;
        logic         address_space_id_dc;
    } bbc_ch_cfg_t;
endpackage

// >>> logic/bbc_top.sv
`timescale 1ns/1ps
`include "bbc_params.svh"
//////////////////////////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////////////////////////
module bbc_top #(
    parameter bit HAS_MMU = 1'b1
) (
    input  wire logic        CLK,            // Processor clock, 40 MHz
    input  wire logic        RST_N,          // Asynchronous reset, active low
    input  wire logic [7:0]  AWADDR,         // Write address
    input  wire logic        AWVALID,        // Write address valid
    output logic             AWREADY,        // Write address ready
    input  wire logic [31:0] WDATA,          // Write data
    input  wire logic [3:0]  WSTRB,          // Write byte strobes
    input  wire logic        WVALID,         // Write data valid
    output logic             WREADY,         // Write data ready
    output logic [1:0]       BRESP,          // Write response
    output logic             BVALID,         // Write response valid
    input  wire logic        BREADY,         // Write response ready
    input  wire logic [7:0]  ARADDR,         // Read address
    input  wire logic        ARVALID,        // Read address valid
    output logic             ARREADY,        // Read address ready
    output logic [31:0]      RDATA,          // Read data
    output logic [1:0]       RRESP,          // Read response
    output logic             RVALID,         // Read data valid
    input  wire logic        RREADY,         // Read data ready
    input  wire logic        BUS_VALID,      // A bus cycle completes this clock
    input  wire logic [31:0] BUS_ADDR,       // Bus cycle address
    input  wire logic        BUS_WRITE,      // Bus cycle is a write
    input  wire logic        BUS_DMA,        // Bus cycle issued by the DMA controller
    input  wire logic [7:0]  BUS_ADDRESS_SPACE_ID,       // Current address_space_id
    input  wire logic        BUS_IO_AREA,    // Bus cycle targets the internal I/O area
    input  wire logic        TLB_LOAD_DONE,  // tlb_load_instruction finished executing
    output logic             BREAK_REQ,      // One-cycle break request
    output logic [2:0]       BREAK_CH,       // Channels that caused BREAK_REQ
    output logic             IRQ             // Level interrupt
);
    //////////////////////////////////////////////////////////////////////////////////////////////
    // Register file
    bbc_pkg::bbc_ch_cfg_t  cfg1;
    bbc_pkg::bbc_ch_cfg_t  cfg2;
    logic [31:0]           addr1;
    logic [31:0]           mask1;
    logic [31:0]           addr2;
    logic [31:0]           mask2;
    logic [11:0]           count_target;
    logic [2:0]            ch3_cfg;
    logic [2:0]            status;
    logic [2:0]            irq_mask;
    logic [11:0]           count_now;

    logic                  aw_got;
    logic                  w_got;
    logic [7:0]            aw_addr;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  do_write;
    logic [31:0]           next_wval;
    logic [2:0]            w1c;
    logic                  bad_wr;

    assign AWREADY  = !aw_got && !BVALID;
    assign WREADY   = !w_got && !BVALID;
    assign do_write = aw_got && w_got && !BVALID;
    assign w1c      = (do_write && aw_addr == `BBC_OFS_STATUS && w_strb[0]) ? w_data[2:0] : 3'h0;

    always_comb begin
        next_wval = 32'h0;
        case (aw_addr)
            `BBC_OFS_CH1_CFG:   next_wval = 32'(cfg1);
            `BBC_OFS_CH2_CFG:   next_wval = 32'(cfg2);
            `BBC_OFS_CH1_ADDR:  next_wval = addr1;
            `BBC_OFS_CH1_MASK:  next_wval = mask1;
            `BBC_OFS_CH2_ADDR:  next_wval = addr2;
            `BBC_OFS_CH2_MASK:  next_wval = mask2;
            `BBC_OFS_CH1_COUNT: next_wval = 32'(count_target);
            `BBC_OFS_CH3_CFG:   next_wval = 32'(ch3_cfg);
            `BBC_OFS_IRQ_MASK:  next_wval = 32'(irq_mask);
            default:            next_wval = 32'h0;
        endcase
        for (int i = 0; i < 4; i++) begin
            if (w_strb[i]) begin
                next_wval[i*8 +: 8] = w_data[i*8 +: 8];
            end
        end
    end

    always_comb begin
        case (aw_addr)
            `BBC_OFS_CH1_CFG, `BBC_OFS_CH2_CFG, `BBC_OFS_CH1_ADDR, `BBC_OFS_CH1_MASK,
            `BBC_OFS_CH2_ADDR, `BBC_OFS_CH2_MASK, `BBC_OFS_CH1_COUNT, `BBC_OFS_CH3_CFG,
            `BBC_OFS_STATUS, `BBC_OFS_IRQ_MASK, `BBC_OFS_CNT_NOW: bad_wr = 1'b0;
            default: bad_wr = 1'b1;
        endcase
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            BVALID  <= 1'b0;
            BRESP   <= 2'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_got  <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_got  <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (do_write) begin
                aw_got <= 1'b0;
                w_got  <= 1'b0;
                BVALID <= 1'b1;
                BRESP  <= bad_wr ? 2'h2 : 2'h0;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg1         <= bbc_pkg::bbc_ch_cfg_t'(`BBC_RST_CFG);
            cfg2         <= bbc_pkg::bbc_ch_cfg_t'(`BBC_RST_CFG);
            addr1        <= 32'h0;
            mask1        <= 32'h0;
            addr2        <= 32'h0;
            mask2        <= 32'h0;
            count_target <= `BBC_RST_COUNT;
            ch3_cfg      <= 3'h0;
            irq_mask     <= 3'h0;
        end else if (do_write) begin
            case (aw_addr)
                `BBC_OFS_CH1_CFG:   cfg1         <= bbc_pkg::bbc_ch_cfg_t'(next_wval[15:0]);
                `BBC_OFS_CH2_CFG:   cfg2         <= bbc_pkg::bbc_ch_cfg_t'(next_wval[15:0]);
                `BBC_OFS_CH1_ADDR:  addr1        <= next_wval;
                `BBC_OFS_CH1_MASK:  mask1        <= next_wval;
                `BBC_OFS_CH2_ADDR:  addr2        <= next_wval;
                `BBC_OFS_CH2_MASK:  mask2        <= next_wval;
                `BBC_OFS_CH1_COUNT: count_target <= next_wval[11:0];
                `BBC_OFS_CH3_CFG:   ch3_cfg      <= next_wval[2:0];
                `BBC_OFS_IRQ_MASK:  irq_mask     <= next_wval[2:0];
                default: ;
            endcase
        end
    end

    // Read channel
    assign ARREADY = !RVALID;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RVALID <= 1'b0;
            RDATA  <= 32'h0;
            RRESP  <= 2'h0;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP  <= 2'h0;
            case (ARADDR)
                `BBC_OFS_CH1_CFG:   RDATA <= 32'(cfg1);
                `BBC_OFS_CH2_CFG:   RDATA <= 32'(cfg2);
                `BBC_OFS_CH1_ADDR:  RDATA <= addr1;
                `BBC_OFS_CH1_MASK:  RDATA <= mask1;
                `BBC_OFS_CH2_ADDR:  RDATA <= addr2;
                `BBC_OFS_CH2_MASK:  RDATA <= mask2;
                `BBC_OFS_CH1_COUNT: RDATA <= 32'(count_target);
                `BBC_OFS_CH3_CFG:   RDATA <= 32'(ch3_cfg);
                `BBC_OFS_STATUS:    RDATA <= 32'(status);
                `BBC_OFS_IRQ_MASK:  RDATA <= 32'(irq_mask);
                `BBC_OFS_CNT_NOW:   RDATA <= 32'(count_now);
                default: begin
                    RDATA <= 32'h0;
                    RRESP <= 2'h2;
                end
            endcase
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Condition matching
    bbc_pkg::bbc_bus_cycle_t cyc;
    logic                    address_space_id_ok1;
    logic                    address_space_id_ok2;
    logic                    match1;
    logic                    match2;
    logic                    io_hit;
    logic                    hit3;
    logic                    count_done;
    logic [2:0]              next_break;

    assign cyc = '{valid: BUS_VALID, addr: BUS_ADDR, write: BUS_WRITE, dma: BUS_DMA,
                   address_space_id: BUS_ADDRESS_SPACE_ID};

    function automatic logic bus_ok(input bbc_pkg::bbc_bus_sel_t sel, input logic dma);
        case (sel)
            bbc_pkg::BS_ALL:  bus_ok = 1'b1;
            bbc_pkg::BS_DATA: bus_ok = !dma;
            bbc_pkg::BS_DMA:  bus_ok = dma;
            default:          bus_ok = 1'b0;
        endcase
    endfunction

    function automatic logic dir_ok(input bbc_pkg::bbc_dir_sel_t sel, input logic wr);
        case (sel)
            bbc_pkg::DIR_RW:    dir_ok = 1'b1;
            bbc_pkg::DIR_READ:  dir_ok = !wr;
            bbc_pkg::DIR_WRITE: dir_ok = wr;
            default:            dir_ok = 1'b0;
        endcase
    endfunction

    generate
        if (HAS_MMU) begin : g_address_space_id
            assign address_space_id_ok1 = cfg1.address_space_id_dc || (cyc.address_space_id == cfg1.address_space_id);
            assign address_space_id_ok2 = cfg2.address_space_id_dc || (cyc.address_space_id == cfg2.address_space_id);
        end else begin : g_no_address_space_id
            assign address_space_id_ok1 = 1'b1;
            assign address_space_id_ok2 = 1'b1;
        end
    endgenerate

    // Masked address bits always compare equal
    assign match1 = cyc.valid && address_space_id_ok1 && bus_ok(cfg1.bus, cyc.dma)
                 && dir_ok(cfg1.dir, cyc.write)
                 && (cfg1.addr_dc || ((cyc.addr ^ addr1) & ~mask1) == 32'h0);
    assign match2 = cyc.valid && address_space_id_ok2 && bus_ok(cfg2.bus, cyc.dma)
                 && dir_ok(cfg2.dir, cyc.write)
                 && (cfg2.addr_dc || ((cyc.addr ^ addr2) & ~mask2) == 32'h0);

    assign io_hit = ch3_cfg[`BBC_CH3_IO_EN] && cyc.valid && BUS_IO_AREA
                 && (!ch3_cfg[`BBC_CH3_IO_WR] || cyc.write);
    assign hit3   = io_hit || (ch3_cfg[`BBC_CH3_TLB_EN] && TLB_LOAD_DONE);

    // A target of zero is treated as one
    assign count_done = cfg1.count_dc || (count_now + 12'h001 >= count_target);

    assign next_break = {hit3, match2, match1 && count_done};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            count_now <= 12'h000;
        end else if (do_write && aw_addr == `BBC_OFS_CH1_COUNT) begin
            count_now <= 12'h000;
        end else if (match1 && !cfg1.count_dc) begin
            count_now <= count_done ? 12'h000 : count_now + 12'h001;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BREAK_REQ <= 1'b0;
            BREAK_CH  <= 3'h0;
        end else begin
            BREAK_REQ <= |next_break;
            BREAK_CH  <= next_break;
        end
    end

    // Sticky status, a new event wins over a clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            status <= 3'h0;
        end else begin
            status <= (status & ~w1c) | next_break;
        end
    end

    assign IRQ = |(status & irq_mask);

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_ch1_hit;
        match1 && count_done;
    endsequence
    sequence s_break_out(int ch);
        ##1 BREAK_REQ && BREAK_CH[ch];
    endsequence

    property p_ch1_break;
        @(posedge CLK) disable iff (!RST_N) s_ch1_hit |-> s_break_out(0);
    endproperty
    a_ch1_break: assert property (p_ch1_break) else $error("channel 1 break missing");

    property p_ch1_wait;
        @(posedge CLK) disable iff (!RST_N)
            !cfg1.count_dc && !match1 |=> !BREAK_CH[0];
    endproperty
    a_ch1_wait: assert property (p_ch1_wait) else $error("channel 1 broke without match");

    property p_ch1_nocount;
        @(posedge CLK) disable iff (!RST_N) cfg1.count_dc && match1 |-> s_break_out(0);
    endproperty
    a_ch1_nocount: assert property (p_ch1_nocount) else $error("first match ignored");

    property p_count_step;
        @(posedge CLK) disable iff (!RST_N)
            match1 && !count_done && !cfg1.count_dc && !do_write
            |=> count_now == $past(count_now) + 12'h001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not advance");

    property p_ch2_first;
        @(posedge CLK) disable iff (!RST_N) match2 |-> s_break_out(1);
    endproperty
    a_ch2_first: assert property (p_ch2_first) else $error("channel 2 break missing");

    property p_dir_read;
        @(posedge CLK) disable iff (!RST_N)
            cfg2.dir == bbc_pkg::DIR_READ && BUS_WRITE |=> !BREAK_CH[1];
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("write broke read-only channel");

    property p_dma_only;
        @(posedge CLK) disable iff (!RST_N)
            cfg2.bus == bbc_pkg::BS_DMA && !BUS_DMA |=> !BREAK_CH[1];
    endproperty
    a_dma_only: assert property (p_dma_only) else $error("cpu cycle broke DMA channel");

    property p_tlb_off;
        @(posedge CLK) disable iff (!RST_N)
            !ch3_cfg[`BBC_CH3_TLB_EN] && !io_hit |=> !BREAK_CH[2];
    endproperty
    a_tlb_off: assert property (p_tlb_off) else $error("channel 3 broke while idle");

    property p_io_write;
        @(posedge CLK) disable iff (!RST_N)
            ch3_cfg[`BBC_CH3_IO_EN] && ch3_cfg[`BBC_CH3_IO_WR] && BUS_VALID && BUS_IO_AREA
            && !BUS_WRITE && !(ch3_cfg[`BBC_CH3_TLB_EN] && TLB_LOAD_DONE) |=> !BREAK_CH[2];
    endproperty
    a_io_write: assert property (p_io_write) else $error("read broke write-only I/O");

    property p_sticky;
        @(posedge CLK) disable iff (!RST_N) BREAK_REQ |-> (status & BREAK_CH) == BREAK_CH;
    endproperty
    a_sticky: assert property (p_sticky) else $error("break not recorded in status");
endmodule

// >>> tb/bbc_bus_model.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module bbc_bus_model (
    input  wire logic               CLK,  // Processor clock
    output bbc_pkg::bbc_bus_cycle_t cyc,  // Bus cycle toward the unit
    output logic                    io,   // Cycle hits internal I/O area
    output logic                    tlb   // TLB load instruction finished
);
    initial begin
        cyc = '0;
        io = 1'b0;
        tlb = 1'b0;
    end
    // One cycle, then an idle pattern unlike the last one
    task automatic issue(input bbc_pkg::bbc_bus_cycle_t c, input logic i, input logic t);
        @(posedge CLK);
        cyc <= c;
        io <= i;
        tlb <= t;
        @(posedge CLK);
        cyc <= {1'b0, ~c.addr, ~c.write, ~c.dma, ~c.address_space_id};
        io <= ~i;
        tlb <= 1'b0;
    endtask
endmodule

// >>> tb/bus_break_condition_unit_tb.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module bus_break_condition_unit_tb;
    logic CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, BVALID, RVALID, IRQ;
    logic AWREADY, WREADY, ARREADY, BREAK_REQ, io, tlb, io_r;
    logic [3:0]  WSTRB;
    logic [7:0]  AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, rd, cfg1, cfg2, ref1, ref2, msk1, msk2;
    logic [1:0]  BRESP, RRESP, rs;
    logic [2:0]  BREAK_CH, cfg3, ex, status;
    logic [11:0] target, cnt;
    bbc_pkg::bbc_bus_cycle_t cyc, c;
    int miscompares = 0;
    int comparisons = 0;

    bbc_top dut_u (.CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .BUS_VALID(cyc.valid), .BUS_ADDR(cyc.addr),
        .BUS_WRITE(cyc.write), .BUS_DMA(cyc.dma), .BUS_ADDRESS_SPACE_ID(cyc.address_space_id), .BUS_IO_AREA(io),
        .TLB_LOAD_DONE(tlb), .BREAK_REQ(BREAK_REQ), .BREAK_CH(BREAK_CH), .IRQ(IRQ));
    bbc_bus_model bus_u (.CLK(CLK), .cyc(cyc), .io(io), .tlb(tlb));

    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(negedge CLK);
            aw = AWVALID && AWREADY;
            w = WVALID && WREADY;
            @(posedge CLK);
            if (aw) AWVALID <= 1'b0;
            if (w) WVALID <= 1'b0;
        end while (!(aw && !WVALID) && !(w && !AWVALID) && !(aw && w));
        do @(negedge CLK); while (!BVALID);
        rs = BRESP;
        @(posedge CLK);
        BREADY <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(negedge CLK); while (!ARREADY);
        @(posedge CLK);
        ARVALID <= 1'b0;
        do @(negedge CLK); while (!RVALID);
        rd = RDATA;
        rs = RRESP;
        @(posedge CLK);
        RREADY <= 1'b0;
    endtask

    // Expected match of one address channel
    function automatic logic hit(input logic [31:0] g, input logic [31:0] r,
                                 input logic [31:0] m, input bbc_pkg::bbc_bus_cycle_t b);
        logic s, a, u, d;
        s = g[0] || b.address_space_id == g[15:8];
        a = g[1] || ((b.addr ^ r) & ~m) == 32'h0;
        u = g[3:2] == 2'h0 || (g[3:2] == 2'h1 && !b.dma) || (g[3:2] == 2'h2 && b.dma);
        d = g[5:4] == 2'h0 || (g[5:4] == 2'h1 && !b.write) || (g[5:4] == 2'h2 && b.write);
        return b.valid && s && a && u && d;
    endfunction

    initial begin
        {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
        {AWADDR, ARADDR, WDATA} = '0;
        WSTRB = 4'hf;
        RST_N = 1'b0;
        status = 3'h0;
        void'($urandom(88));
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        axi_rd(8'h00);
        check(rd, 32'h3);
        axi_rd(8'h18);
        check(rd, 32'h1);
        axi_rd(8'h24);
        check(rd, 32'h0);
        axi_rd(8'h3c);
        check(rs, 2'h2);
        check(rd, 32'h0);
        axi_wr(8'h3c, 32'hffff_ffff);
        check(rs, 2'h2);
        for (int i = 0; i < 36; i++) begin
            cfg1 = {16'h0, 8'($urandom_range(3)), 1'b0, 1'($urandom), 2'(i % 3),
                    2'((i / 3) % 3), 2'($urandom)};
            cfg2 = {16'h0, 8'($urandom_range(3)), 2'h0, 2'($urandom_range(2)),
                    2'($urandom_range(2)), 2'($urandom)};
            ref1 = $urandom;
            ref2 = $urandom;
            msk1 = $urandom_range(15);
            msk2 = $urandom_range(15);
            cfg3 = 3'($urandom);
            target = 12'($urandom_range(3));
            if (i == 35) target = 12'hfff;
            cnt = 12'h0;
            axi_wr(8'h00, cfg1);
            axi_wr(8'h04, cfg2);
            axi_wr(8'h08, ref1);
            axi_wr(8'h0c, msk1);
            axi_wr(8'h10, ref2);
            axi_wr(8'h14, msk2);
            axi_wr(8'h1c, {29'h0, cfg3});
            axi_wr(8'h18, {20'h0, target});
            for (int k = 0; k < 10; k++) begin
                c = {1'($urandom_range(3) != 0), (k[0] ? ref1 : ref2) ^ $urandom_range(15),
                     1'($urandom), 1'($urandom), 8'($urandom_range(3))};
                io_r = 1'($urandom);
                ex = 3'h0;
                if (hit(cfg1, ref1, msk1, c)) begin
                    cnt++;
                    if (cfg1[6] || cnt >= (target == 0 ? 12'h1 : target)) begin
                        ex[0] = 1'b1;
                        cnt = 12'h0;
                    end
                end
                ex[1] = hit(cfg2, ref2, msk2, c);
                ex[2] = (cfg3[1] && c.valid && io_r && (!cfg3[2] || c.write))
                        || (cfg3[0] && k[1]);
                bus_u.issue(c, io_r, k[1]);
                @(negedge CLK);
                check(BREAK_REQ, |ex);
                check(BREAK_CH, ex);
                status |= ex;
            end
            axi_rd(8'h00);
            check(rd, cfg1);
            check(rs, 2'h0);
            axi_rd(8'h28);
            check(rd, {20'h0, cnt});
        end
        // Partial write: only the two low byte lanes land
        WSTRB <= 4'h3;
        axi_wr(8'h08, 32'h1234_5678);
        check(rs, 2'h0);
        WSTRB <= 4'hf;
        axi_rd(8'h08);
        check(rd, {ref1[31:16], 16'h5678});
        axi_rd(8'h20);
        check(rd, {29'h0, status});
        check(IRQ, 1'b0);
        axi_wr(8'h24, 32'h7);
        check(IRQ, |status);
        axi_wr(8'h20, 32'h7);
        axi_rd(8'h20);
        check(rd, 32'h0);
        check(IRQ, 1'b0);
        stop_test();
    end

    initial begin
        #(25 * 40000);
        miscompares++;
        stop_test();
    end
endmodule
